// *** src/sbni_issue_ctrl.sv ***
// issue and timing control for boolean, shift and normalize units
// Summary of operation
// - opcode 16 writes first source OR complement of second source.
// - opcode 17 writes first source XOR complement of second source.
// - boolean issues only with free registers, free write path, no stack backup.
// - after issue nothing stalls; every later step is on a fixed schedule.
// - boolean and shift results are written one clock after issue.
// - boolean and shift destination stays reserved from issue until delivery.
// - at issue load the next parcel and send sources to the unit.
// - clock after issue: next may issue, result written, busy flag set.
// - go boolean set the clock after issue, cleared one clock later.
// - opcodes 20 and 21 read only the destination register and need it free.
// - opcodes 22 and 23 need destination, second source and count index free.
// - normalize needs three registers free, both paths free two ahead, no backup.
// - normalize delivers word and count two clocks after issue, never delayed.
// - normalize destination and count index stay reserved for two clocks.
// - normalize sends second source at issue; count computed the next clock.
// - first clock after normalize issue sets both busy flags and go normalize.
// - second clock after normalize issue writes results, clears go normalize.
// - third clock after normalize issue clears both busy flags.
// - opcode 25 follows the same conditions and schedule as normalize.
`timescale 1ns/1ps
module sbni_issue_ctrl (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic issue_valid_i,
  input wire logic [sbni_pkg::PARCEL_W-1:0] issue_word_i,
  input wire logic [sbni_pkg::REG_N-1:0] x_reserved_i,
  input wire logic [sbni_pkg::REG_N-1:0] b_reserved_i,
  input wire logic x_path_free_next_i,
  input wire logic x_path_free_2_i,
  input wire logic b_path_free_2_i,
  input wire logic stack_backup_i,
  output logic [sbni_pkg::ADDR_W-1:0] x_rd_a_addr_o,
  output logic [sbni_pkg::ADDR_W-1:0] x_rd_b_addr_o,
  output logic [sbni_pkg::ADDR_W-1:0] b_rd_addr_o,
  input wire logic [sbni_pkg::WORD_W-1:0] x_rd_a_data_i,
  input wire logic [sbni_pkg::WORD_W-1:0] x_rd_b_data_i,
  input wire logic [sbni_pkg::IDX_W-1:0] b_rd_data_i,
  output logic issue_ready_o,
  output logic issue_word_load_o,
  output logic x_write_o,
  output logic [sbni_pkg::ADDR_W-1:0] x_write_addr_o,
  output logic [sbni_pkg::WORD_W-1:0] x_write_data_o,
  output logic b_write_o,
  output logic [sbni_pkg::ADDR_W-1:0] b_write_addr_o,
  output logic [sbni_pkg::IDX_W-1:0] b_write_data_o,
  output logic [sbni_pkg::REG_N-1:0] x_busy_o,
  output logic [sbni_pkg::REG_N-1:0] b_busy_o,
  output logic go_boolean_o,
  output logic go_shift_o,
  output logic go_normalize_o
);
  import sbni_pkg::*;

  function automatic logic [REG_N-1:0] onehot(input logic [ADDR_W-1:0] a);
    onehot = 8'(1) << a;
  endfunction : onehot

  // left is circular, right is arithmetic and saturates to the sign
  function automatic logic [WORD_W-1:0] shift_word(input logic [WORD_W-1:0] w,
                                                   input logic left,
                                                   input logic [IDX_W-1:0] amt);
    logic [2*WORD_W-1:0] dbl;
    logic [5:0] a;
    a = (amt[5:0] >= 6'h3C) ? 6'(amt[5:0] - 6'h3C) : amt[5:0];
    dbl = {w, w} << a;
    if (left) begin
      shift_word = dbl[2*WORD_W-1:WORD_W];
    end else if (amt > 18'(WORD_W - 1)) begin
      shift_word = {WORD_W{w[SIGN_BIT]}};
    end else begin
      shift_word = WORD_W'($signed(w) >>> amt);
    end
  endfunction : shift_word

  logic [OP_W-1:0] op;
  logic [ADDR_W-1:0] fld_i;
  logic [ADDR_W-1:0] fld_j;
  logic [ADDR_W-1:0] fld_k;
  logic is_bool;
  logic is_sh_imm;
  logic is_sh_nom;
  logic is_norm;
  logic [REG_N-1:0] x_res;
  logic [REG_N-1:0] b_res;
  logic x_free_next;
  logic accept;
  logic acc_bs;
  logic acc_norm;
  logic [WORD_W-1:0] unit_res;
  logic nom_neg;
  logic [IDX_W-1:0] nom_mag;

  assign op = issue_word_i[OP_LSB +: OP_W];
  assign fld_i = issue_word_i[FI_LSB +: ADDR_W];
  assign fld_j = issue_word_i[FJ_LSB +: ADDR_W];
  assign fld_k = issue_word_i[FK_LSB +: ADDR_W];
  assign is_bool = (op == OP_AND_NOT) || (op == OP_OR_NOT) || (op == OP_XOR_NOT);
  assign is_sh_imm = (op == OP_ROT_L) || (op == OP_ASR);
  assign is_sh_nom = (op == OP_NOM_L) || (op == OP_NOM_R);
  assign is_norm = (op == OP_NORM) || (op == OP_RNORM);

  // reservations seen by issue: other units plus our own busy flags
  assign x_res = x_reserved_i | x_busy_o;
  assign b_res = b_reserved_i | b_busy_o;
  // a normalize in its count period owns the write path next period
  assign x_free_next = x_path_free_next_i && !go_normalize_o;

  always_comb begin
    issue_ready_o = 1'b0;
    if (!stack_backup_i) begin
      if (is_bool) begin
        issue_ready_o = !x_res[fld_i] && !x_res[fld_j] && !x_res[fld_k]
                        && x_free_next;
      end else if (is_sh_imm) begin
        issue_ready_o = !x_res[fld_i] && x_free_next;
      end else if (is_sh_nom) begin
        issue_ready_o = !x_res[fld_i] && !x_res[fld_k] && !b_res[fld_j]
                        && x_free_next;
      end else if (is_norm) begin
        issue_ready_o = !x_res[fld_i] && !x_res[fld_k] && !b_res[fld_j]
                        && x_path_free_2_i && b_path_free_2_i;
      end
    end
  end

  assign accept = issue_valid_i && issue_ready_o;
  assign acc_bs = accept && (is_bool || is_sh_imm || is_sh_nom);
  assign acc_norm = accept && is_norm;
  // issue period: fetch next parcel and read sources for the unit
  assign issue_word_load_o = accept;
  assign x_rd_a_addr_o = is_sh_imm ? fld_i : fld_j;
  assign x_rd_b_addr_o = fld_k;
  assign b_rd_addr_o = fld_j;

  always_comb begin
    nom_neg = b_rd_data_i[IDX_W-1];
    nom_mag = nom_neg ? ~b_rd_data_i : b_rd_data_i;
    unit_res = WORD_RST;
    unique case (op)
      OP_AND_NOT: unit_res = x_rd_a_data_i & ~x_rd_b_data_i;
      OP_OR_NOT: unit_res = x_rd_a_data_i | ~x_rd_b_data_i;
      OP_XOR_NOT: unit_res = x_rd_a_data_i ^ ~x_rd_b_data_i;
      OP_ROT_L: unit_res = shift_word(x_rd_a_data_i, 1'b1, 18'({fld_j, fld_k}));
      OP_ASR: unit_res = shift_word(x_rd_a_data_i, 1'b0, 18'({fld_j, fld_k}));
      OP_NOM_L: unit_res = shift_word(x_rd_b_data_i, !nom_neg, nom_mag);
      OP_NOM_R: unit_res = shift_word(x_rd_b_data_i, nom_neg, nom_mag);
      default: unit_res = WORD_RST;
    endcase
  end

  // normalize unit input register, loaded at issue
  logic [WORD_W-1:0] norm_in;
  logic norm_round;
  logic [ADDR_W-1:0] norm_i;
  logic [ADDR_W-1:0] norm_j;
  logic [WORD_W-1:0] next_norm_in;
  logic next_norm_round;
  logic [ADDR_W-1:0] next_norm_i;
  logic [ADDR_W-1:0] next_norm_j;
  logic [WORD_W-1:0] norm_res;
  logic [CNT_W:0] norm_cnt;

  sbni_norm_unit u_norm (
    .operand_i(norm_in),
    .round_i(norm_round),
    .result_o(norm_res),
    .count_o(norm_cnt)
  );

  always_comb begin
    next_norm_in = norm_in;
    next_norm_round = norm_round;
    next_norm_i = norm_i;
    next_norm_j = norm_j;
    if (acc_norm) begin
      next_norm_in = x_rd_b_data_i;
      next_norm_round = (op == OP_RNORM);
      next_norm_i = fld_i;
      next_norm_j = fld_j;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      norm_in <= WORD_RST;
      norm_round <= 1'b0;
      norm_i <= 3'h0;
      norm_j <= 3'h0;
    end else begin
      norm_in <= next_norm_in;
      norm_round <= next_norm_round;
      norm_i <= next_norm_i;
      norm_j <= next_norm_j;
    end
  end

  // schedule state: flags, busy bits and the write ports
  logic next_go_boolean;
  logic next_go_shift;
  logic next_go_normalize;
  logic [REG_N-1:0] next_x_busy;
  logic [REG_N-1:0] next_b_busy;
  logic next_x_write;
  logic [ADDR_W-1:0] next_x_write_addr;
  logic [WORD_W-1:0] next_x_write_data;
  logic next_b_write;
  logic [ADDR_W-1:0] next_b_write_addr;
  logic [IDX_W-1:0] next_b_write_data;

  always_comb begin
    next_go_boolean = acc_bs && is_bool;
    next_go_shift = acc_bs && !is_bool;
    next_go_normalize = acc_norm;
    // busy lives one period for boolean and shift, two for normalize
    next_x_busy = BUSY_RST;
    next_b_busy = BUSY_RST;
    if (accept) begin
      next_x_busy = onehot(fld_i);
    end
    if (acc_norm) begin
      next_b_busy = onehot(fld_j);
    end
    if (go_normalize_o) begin
      next_x_busy = next_x_busy | onehot(norm_i);
      next_b_busy = next_b_busy | onehot(norm_j);
    end
    next_x_write = acc_bs || go_normalize_o;
    next_x_write_addr = go_normalize_o ? norm_i : fld_i;
    next_x_write_data = go_normalize_o ? norm_res : unit_res;
    next_b_write = go_normalize_o;
    next_b_write_addr = norm_j;
    next_b_write_data = IDX_RST;
    next_b_write_data[CNT_W:0] = norm_cnt;
    if (!go_normalize_o) begin
      next_b_write_data = b_write_data_o;
    end
  end

  // no stall input exists past issue, so nothing here can wait
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      go_boolean_o <= 1'b0;
      go_shift_o <= 1'b0;
      go_normalize_o <= 1'b0;
      x_busy_o <= BUSY_RST;
      b_busy_o <= BUSY_RST;
      x_write_o <= 1'b0;
      x_write_addr_o <= 3'h0;
      x_write_data_o <= WORD_RST;
      b_write_o <= 1'b0;
      b_write_addr_o <= 3'h0;
      b_write_data_o <= IDX_RST;
    end else begin
      go_boolean_o <= next_go_boolean;
      go_shift_o <= next_go_shift;
      go_normalize_o <= next_go_normalize;
      x_busy_o <= next_x_busy;
      b_busy_o <= next_b_busy;
      x_write_o <= next_x_write;
      x_write_addr_o <= next_x_write_addr;
      x_write_data_o <= next_x_write_data;
      b_write_o <= next_b_write;
      b_write_addr_o <= next_b_write_addr;
      b_write_data_o <= next_b_write_data;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_norm_cp01;
    go_normalize_o && x_busy_o[$past(fld_i)] && b_busy_o[$past(fld_j)];
  endsequence
  sequence s_norm_cp02;
    x_write_o && b_write_o && x_write_addr_o == $past(fld_i, 2)
    && (!go_normalize_o || $past(acc_norm));
  endsequence
  sequence s_norm_cp03;
    !x_busy_o[$past(fld_i, 3)] && !b_busy_o[$past(fld_j, 3)];
  endsequence

  property p_norm_sched;
    acc_norm |=> s_norm_cp01 ##1 s_norm_cp02 ##1 s_norm_cp03;
  endproperty
  a_norm_sched: assert property (p_norm_sched) else $error("normalize schedule broken");

  property p_or_not;
    accept && op == OP_OR_NOT |=> x_write_data_o == $past(x_rd_a_data_i | ~x_rd_b_data_i);
  endproperty
  a_or_not: assert property (p_or_not) else $error("or-not result wrong");

  property p_xor_not;
    accept && op == OP_XOR_NOT |=> x_write_data_o == $past(x_rd_a_data_i ^ ~x_rd_b_data_i);
  endproperty
  a_xor_not: assert property (p_xor_not) else $error("xor-not result wrong");

  property p_bool_issue;
    accept && is_bool |-> !stack_backup_i && !x_busy_o[fld_j] && !x_busy_o[fld_k]
                          && !x_reserved_i[fld_i] && x_path_free_next_i;
  endproperty
  a_bool_issue: assert property (p_bool_issue) else $error("boolean issued while blocked");

  property p_bs_busy;
    acc_bs |=> x_busy_o[$past(fld_i)] && x_write_o ##1 !x_busy_o[$past(fld_i, 2)];
  endproperty
  a_bs_busy: assert property (p_bs_busy) else $error("short busy window wrong");

  property p_go_bool;
    accept && is_bool |=> go_boolean_o && !go_shift_o && x_write_addr_o == $past(fld_i);
  endproperty
  a_go_bool: assert property (p_go_bool) else $error("go boolean not set after issue");

  property p_go_shift;
    accept && (is_sh_imm || is_sh_nom) |=> go_shift_o && !go_boolean_o && x_write_o;
  endproperty
  a_go_shift: assert property (p_go_shift) else $error("go shift not set after issue");

  property p_norm_issue;
    acc_norm |-> x_path_free_2_i && b_path_free_2_i && !b_reserved_i[fld_j]
                 && !stack_backup_i;
  endproperty
  a_norm_issue: assert property (p_norm_issue) else $error("normalize issued while blocked");

  property p_imm_src;
    accept && is_sh_imm |-> x_rd_a_addr_o == fld_i && issue_word_load_o;
  endproperty
  a_imm_src: assert property (p_imm_src) else $error("shift source not destination");
endmodule : sbni_issue_ctrl

// *** src/sbni_norm_unit.sv ***
// normalize network: coefficient left shift, exponent reduce, count
`timescale 1ns/1ps
module sbni_norm_unit (
  input wire logic [sbni_pkg::WORD_W-1:0] operand_i,
  input wire logic round_i,
  output logic [sbni_pkg::WORD_W-1:0] result_o,
  output logic [sbni_pkg::CNT_W:0] count_o
);
  import sbni_pkg::*;

  logic sign;
  logic [WORD_W-1:0] mag;
  logic [COEF_W-1:0] coef;
  logic [EXP_MSB-EXP_LSB:0] exp_in;
  logic [COEF_W:0] ext;
  logic [COEF_W:0] shifted;
  logic [WORD_W-1:0] pos_res;

  always_comb begin
    sign = operand_i[SIGN_BIT];
    // negative words are handled as their ones complement
    mag = sign ? ~operand_i : operand_i;
    coef = mag[COEF_MSB:0];
    exp_in = mag[EXP_MSB:EXP_LSB];
    count_o = 7'(COEF_W);
    for (int p = 0; p < COEF_W; p++) begin
      if (coef[p]) begin
        count_o = 7'(COEF_MSB - p);
      end
    end
    // round bit sits half an lsb below the coefficient
    ext = {coef, round_i};
    shifted = ext << count_o;
    pos_res = {1'b0, exp_in - 11'(count_o), shifted[COEF_W:1]};
    if (count_o == 7'(COEF_W)) begin
      pos_res = WORD_RST;
    end
    // a zero coefficient stays plus zero even for a negative input
    result_o = (sign && count_o != 7'(COEF_W)) ? ~pos_res : pos_res;
  end
endmodule : sbni_norm_unit

// *** src/sbni_pkg.sv ***
// shared constants of the shift, boolean and normalize issue block
package sbni_pkg;
  localparam int WORD_W = 60;
  localparam int IDX_W = 18;
  localparam int REG_N = 8;
  localparam int ADDR_W = 3;
  localparam int OP_W = 6;
  localparam int PARCEL_W = 15;
  // parcel field positions
  localparam int OP_LSB = 9;
  localparam int FI_LSB = 6;
  localparam int FJ_LSB = 3;
  localparam int FK_LSB = 0;
  // floating word layout
  localparam int SIGN_BIT = 59;
  localparam int EXP_MSB = 58;
  localparam int EXP_LSB = 48;
  localparam int COEF_MSB = 47;
  localparam int COEF_W = 48;
  localparam int CNT_W = 6;
  // opcodes of this block
  localparam logic [5:0] OP_AND_NOT = 6'h0D;
  localparam logic [5:0] OP_OR_NOT = 6'h0E;
  localparam logic [5:0] OP_XOR_NOT = 6'h0F;
  localparam logic [5:0] OP_ROT_L = 6'h10;
  localparam logic [5:0] OP_ASR = 6'h11;
  localparam logic [5:0] OP_NOM_L = 6'h12;
  localparam logic [5:0] OP_NOM_R = 6'h13;
  localparam logic [5:0] OP_NORM = 6'h14;
  localparam logic [5:0] OP_RNORM = 6'h15;
  // schedule, in clock periods after issue
  localparam int BOOL_DELIVER_CP = 1;
  localparam int NORM_DELIVER_CP = 2;
  // reset values
  localparam logic [7:0] BUSY_RST = 8'h00;
  localparam logic [59:0] WORD_RST = 60'h000000000000000;
  localparam logic [17:0] IDX_RST = 18'h00000;
endpackage : sbni_pkg

// *** verif/sbni_regfile_model.sv ***
// behavioural operand register file on the far side of the issue block
`timescale 1ns/1ps
module sbni_regfile_model (
  input wire logic clk_i,
  input wire logic [sbni_pkg::ADDR_W-1:0] x_rd_a_addr_i,
  input wire logic [sbni_pkg::ADDR_W-1:0] x_rd_b_addr_i,
  input wire logic [sbni_pkg::ADDR_W-1:0] b_rd_addr_i,
  input wire logic x_write_i,
  input wire logic [sbni_pkg::ADDR_W-1:0] x_write_addr_i,
  input wire logic [sbni_pkg::WORD_W-1:0] x_write_data_i,
  input wire logic b_write_i,
  input wire logic [sbni_pkg::ADDR_W-1:0] b_write_addr_i,
  input wire logic [sbni_pkg::IDX_W-1:0] b_write_data_i,
  output logic [sbni_pkg::WORD_W-1:0] x_rd_a_data_o,
  output logic [sbni_pkg::WORD_W-1:0] x_rd_b_data_o,
  output logic [sbni_pkg::IDX_W-1:0] b_rd_data_o
);
  import sbni_pkg::*;
  // preloaded by the bench; storage has no reset, like the real file
  logic [WORD_W-1:0] x_mem [REG_N];
  logic [IDX_W-1:0] b_mem [REG_N];
  assign x_rd_a_data_o = x_mem[x_rd_a_addr_i];
  assign x_rd_b_data_o = x_mem[x_rd_b_addr_i];
  assign b_rd_data_o = b_mem[b_rd_addr_i];
  always @(posedge clk_i) begin
    if (x_write_i) begin
      x_mem[x_write_addr_i] <= x_write_data_i;
    end
    if (b_write_i) begin
      b_mem[b_write_addr_i] <= b_write_data_i;
    end
  end
endmodule : sbni_regfile_model

// *** verif/testbench.sv ***
// self-checking bench for the shift, boolean and normalize issue block
`timescale 1ns/1ps
module testbench;
  import sbni_pkg::*;
  localparam logic [59:0] XJ_VAL = 60'hF0F0F0F0F0F0F0F;
  localparam logic [59:0] XK_VAL = 60'h923456789ABCDEF;
  localparam logic [59:0] XS_VAL = 60'h800000000000001;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic issue_valid_i = 1'b0;
  logic [PARCEL_W-1:0] issue_word_i = '0;
  logic [REG_N-1:0] x_reserved_i = '0;
  logic [REG_N-1:0] b_reserved_i = '0;
  logic x_path_free_next_i = 1'b1;
  logic x_path_free_2_i = 1'b1;
  logic b_path_free_2_i = 1'b1;
  logic stack_backup_i = 1'b0;
  logic [ADDR_W-1:0] x_rd_a_addr_o, x_rd_b_addr_o, b_rd_addr_o, x_write_addr_o, b_write_addr_o;
  logic [WORD_W-1:0] x_rd_a_data_i, x_rd_b_data_i, x_write_data_o;
  logic [IDX_W-1:0] b_rd_data_i, b_write_data_o;
  logic [REG_N-1:0] x_busy_o, b_busy_o;
  logic issue_ready_o, issue_word_load_o, x_write_o, b_write_o;
  logic go_boolean_o, go_shift_o, go_normalize_o;
  int err_count = 0;
  int checked = 0;
  always #2.5 clk_i = ~clk_i;
  sbni_issue_ctrl u_sbni_issue_ctrl (.clk_i, .rstn_i, .issue_valid_i, .issue_word_i,
    .x_reserved_i, .b_reserved_i, .x_path_free_next_i, .x_path_free_2_i, .b_path_free_2_i,
    .stack_backup_i, .x_rd_a_addr_o, .x_rd_b_addr_o, .b_rd_addr_o, .x_rd_a_data_i,
    .x_rd_b_data_i, .b_rd_data_i, .issue_ready_o, .issue_word_load_o, .x_write_o,
    .x_write_addr_o, .x_write_data_o, .b_write_o, .b_write_addr_o, .b_write_data_o,
    .x_busy_o, .b_busy_o, .go_boolean_o, .go_shift_o, .go_normalize_o);
  sbni_regfile_model u_sbni_regfile_model (.clk_i(clk_i), .x_rd_a_addr_i(x_rd_a_addr_o),
    .x_rd_b_addr_i(x_rd_b_addr_o), .b_rd_addr_i(b_rd_addr_o), .x_write_i(x_write_o),
    .x_write_addr_i(x_write_addr_o), .x_write_data_i(x_write_data_o), .b_write_i(b_write_o),
    .b_write_addr_i(b_write_addr_o), .b_write_data_i(b_write_data_o),
    .x_rd_a_data_o(x_rd_a_data_i), .x_rd_b_data_o(x_rd_b_data_i), .b_rd_data_o(b_rd_data_i));

  task automatic chk(input string name, input logic [59:0] exp, input logic [59:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  function automatic logic [59:0] rotl(input logic [59:0] v, input int n);
    return (v << n) | (v >> (WORD_W - n));
  endfunction : rotl

  function automatic logic [59:0] asr(input logic [59:0] v, input int n);
    return $signed(v) >>> n;
  endfunction : asr

  function automatic logic [PARCEL_W-1:0] pw(input logic [5:0] op, input int i, j, k);
    return {op, 3'(i), 3'(j), 3'(k)};
  endfunction : pw

  // valid stays up so a following call issues back to back
  task automatic issue(input logic [PARCEL_W-1:0] w);
    @(posedge clk_i);
    #1;
    issue_valid_i = 1'b1;
    issue_word_i = w;
    #1;
    chk("issue_ready", 60'h1, {issue_ready_o, issue_word_load_o} == 2'b11);
  endtask : issue

  task automatic idle();
    @(posedge clk_i);
    #1;
    issue_valid_i = 1'b0;
  endtask : idle

  // f packs {x path next, x path two ahead, b path two ahead, stack backup}
  task automatic refuse(input logic [PARCEL_W-1:0] w, input logic [7:0] xr, br,
                        input logic [3:0] f);
    @(posedge clk_i);
    #1;
    {x_reserved_i, b_reserved_i} = {xr, br};
    {x_path_free_next_i, x_path_free_2_i, b_path_free_2_i, stack_backup_i} = f;
    issue_valid_i = 1'b1;
    issue_word_i = w;
    #1;
    chk("refused", 60'h0, issue_ready_o | issue_word_load_o);
    idle();
    {x_reserved_i, b_reserved_i} = '0;
    {x_path_free_next_i, x_path_free_2_i, b_path_free_2_i, stack_backup_i} = 4'hE;
    chk("no_effect", 60'h0, x_write_o | go_boolean_o | go_shift_o | go_normalize_o);
  endtask : refuse

  // called in the first period after issue
  task automatic deliver(input int i, input logic [59:0] exp, input logic gb, gs);
    chk("write_c1", {1'b1, 3'(i)}, {x_write_o, x_write_addr_o});
    chk("data_c1", exp, x_write_data_o);
    chk("busy_c1", 60'h1 << i, x_busy_o);
    chk("go_c1", {gb, gs}, {go_boolean_o, go_shift_o});
    @(posedge clk_i);
    #1;
    chk("clear_c2", 60'h0, {x_write_o, x_busy_o, go_boolean_o, go_shift_o});
    chk("result_c2", exp, u_sbni_regfile_model.x_mem[i]);
  endtask : deliver

  task automatic run(input logic [PARCEL_W-1:0] w, input int i, input logic [59:0] exp,
                     input logic gb, gs);
    issue(w);
    idle();
    deliver(i, exp, gb, gs);
  endtask : run

  task automatic norm(input logic [5:0] op, input logic [59:0] exp_w);
    issue(pw(op, 7, 3, 0));
    idle();
    chk("go_norm_c1", 60'h1, go_normalize_o);
    chk("busy_c1", {8'h08, 8'h80}, {b_busy_o, x_busy_o});
    chk("no_early", 60'h0, x_write_o | b_write_o);
    @(posedge clk_i);
    #1;
    chk("go_norm_c2", 60'h0, go_normalize_o);
    chk("busy_c2", {8'h08, 8'h80}, {b_busy_o, x_busy_o});
    chk("writes_c2", {2'b11, 3'h7, 3'h3}, {x_write_o, b_write_o, x_write_addr_o, b_write_addr_o});
    chk("count", 18'h0002F, b_write_data_o);
    chk("norm_word", exp_w, x_write_data_o);
    @(posedge clk_i);
    #1;
    chk("busy_c3", 60'h0, {b_busy_o, x_busy_o});
    chk("b_result", 18'h0002F, u_sbni_regfile_model.b_mem[3]);
    chk("x_result", exp_w, u_sbni_regfile_model.x_mem[7]);
  endtask : norm

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #5000;
    err_count++;
    report_and_stop();
  end

  initial begin
    u_sbni_regfile_model.x_mem[0] = 60'h400000000000001;
    u_sbni_regfile_model.x_mem[2] = XJ_VAL;
    u_sbni_regfile_model.x_mem[3] = XK_VAL;
    u_sbni_regfile_model.x_mem[5] = XS_VAL;
    u_sbni_regfile_model.b_mem[1] = 18'h00004;
    u_sbni_regfile_model.b_mem[2] = 18'h3FFFA;
    repeat (12) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    for (int r = 1; r < 4; r++) begin
      refuse(pw(OP_OR_NOT, 1, 2, 3), 8'h01 << r, 8'h00, 4'hE);
    end
    refuse(pw(OP_OR_NOT, 1, 2, 3), 8'h00, 8'h00, 4'h6);
    refuse(pw(OP_XOR_NOT, 1, 2, 3), 8'h00, 8'h00, 4'hF);
    run(pw(OP_OR_NOT, 1, 2, 3), 1, XJ_VAL | ~XK_VAL, 1'b1, 1'b0);
    issue(pw(OP_OR_NOT, 4, 2, 3));
    issue(pw(OP_XOR_NOT, 6, 2, 3));
    chk("first_write", {1'b1, 3'h4}, {x_write_o, x_write_addr_o});
    idle();
    deliver(6, XJ_VAL ^ ~XK_VAL, 1'b1, 1'b0);
    run(pw(OP_AND_NOT, 4, 2, 3), 4, XJ_VAL & ~XK_VAL, 1'b1, 1'b0);
    refuse(pw(OP_ROT_L, 5, 7, 3), 8'h20, 8'h00, 4'hE);
    @(posedge clk_i);
    #1;
    x_reserved_i = 8'h81;
    run(pw(OP_ROT_L, 5, 7, 3), 5, rotl(XS_VAL, 59), 1'b0, 1'b1);
    x_reserved_i = 8'h00;
    run(pw(OP_ASR, 5, 1, 1), 5, asr(rotl(XS_VAL, 59), 9), 1'b0, 1'b1);
    refuse(pw(OP_NOM_L, 6, 1, 3), 8'h00, 8'h02, 4'hE);
    refuse(pw(OP_NOM_R, 6, 1, 3), 8'h08, 8'h00, 4'hE);
    run(pw(OP_NOM_L, 6, 1, 3), 6, rotl(XK_VAL, 4), 1'b0, 1'b1);
    run(pw(OP_NOM_L, 6, 2, 3), 6, asr(XK_VAL, 5), 1'b0, 1'b1);
    run(pw(OP_NOM_R, 6, 1, 3), 6, asr(XK_VAL, 4), 1'b0, 1'b1);
    run(pw(OP_NOM_R, 6, 2, 3), 6, rotl(XK_VAL, 5), 1'b0, 1'b1);
    refuse(pw(OP_NORM, 7, 3, 0), 8'h00, 8'h08, 4'hE);
    refuse(pw(OP_NORM, 7, 3, 0), 8'h00, 8'h00, 4'hA);
    refuse(pw(OP_RNORM, 7, 3, 0), 8'h00, 8'h00, 4'hC);
    norm(OP_NORM, 60'h3D1800000000000);
    norm(OP_RNORM, 60'h3D1C00000000000);
    report_and_stop();
  end
endmodule : testbench
